// file: design/cbsc_pkg.sv
package cbsc_pkg;

	// ********************************************************************
	// Bus geometry
	// ********************************************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int DC_W   = 8;
	localparam int SK_W   = 2;
	localparam int EVT_W  = 2;
	localparam int SYNC_W = 3;

	// ********************************************************************
	// Register offsets
	// ********************************************************************
	localparam logic [ADDR_W-1:0] OFS_SYSTEM_CONTROL = 8'h80;
	localparam logic [ADDR_W-1:0] OFS_DEVICE_CONTROL = 8'h91;
	localparam logic [ADDR_W-1:0] OFS_SOCKET_REQ_PIN = 8'h94;
	localparam logic [ADDR_W-1:0] OFS_EVENT_STATUS   = 8'hA0;
	localparam logic [ADDR_W-1:0] OFS_EVENT_MASK     = 8'hA4;

	// ********************************************************************
	// System control layout
	// ********************************************************************
	localparam int SC_BAD_SUPPLY_DISABLE = 21;
	localparam int SC_DMA_ENABLE         = 19;
	localparam int SC_CHAN_LSB           = 16;
	localparam int SC_CHAN_W             = 3;
	localparam int SC_ID_WRITE_ENABLE    = 3;
	localparam int SC_SAMPLING_MODE      = 2;
	localparam int SC_CLOCK_RUN_OVERRIDE = 1;
	localparam logic [DATA_W-1:0] SC_WMASK      = 32'h002F000E; // Bits 21, 19, 18:16, 3:1
	localparam logic [DATA_W-1:0] SC_RESET      = 32'h00040004;
	localparam logic [DATA_W-1:0] SC_FORCE_MASK = 32'h000F0000;
	localparam logic [SC_CHAN_W-1:0] CHAN_DEFAULT = 3'h4;

	// ********************************************************************
	// Device control layout
	// ********************************************************************
	localparam int DC_ZOOMED_VIDEO = 6;
	localparam int DC_SERIAL_LSB   = 3;
	localparam int DC_HOST_INT_MODE = 2;
	localparam int DC_LEGACY_MODE  = 1;
	localparam int DC_FUNC_FLAG    = 0;
	localparam logic [DC_W-1:0] DC_WMASK     = 8'h5E;
	localparam logic [DC_W-1:0] DC_RESET     = 8'h00;
	localparam logic [DC_W-1:0] DC_HOST_PASS = 8'h01;

	// ********************************************************************
	// Socket request pin and event registers
	// ********************************************************************
	localparam logic [SK_W-1:0]  SK_RESET   = 2'h0;
	localparam logic [EVT_W-1:0] EVT_RESET  = 2'h0;
	localparam int EVT_CARD_FUNCTION = 0;
	localparam int EVT_BAD_SUPPLY    = 1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

endpackage : cbsc_pkg

// file: design/cbsc_if.sv
`timescale 1ns/1ns
interface cbsc_if;
	logic [cbsc_pkg::ADDR_W-1:0] addr;
	logic [cbsc_pkg::DATA_W-1:0] wdata;
	logic                        wr;
	logic                        rd;
	logic [cbsc_pkg::DATA_W-1:0] rdata;

	// Register bank end
	modport device (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata
	);

	// Configuring processor end
	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata
	);
endinterface : cbsc_if

// file: design/cbsc_device.sv
`timescale 1ns/1ns
module cbsc_device (
	input  wire logic                         clk_in,
	input  wire logic                         rst_in,
	input  wire logic                         ce_in,
	cbsc_if.device                            bus,
	input  wire logic                         card_request_in,
	input  wire logic                         bad_supply_in,
	input  wire logic                         clock_request_in,
	output logic                              clock_run_n_out,
	output logic                              clock_run_n_oe_out,
	output logic                              card_function_irq_out,
	output logic                              bad_supply_request_out,
	output logic                              identifier_write_enable_out,
	output logic                              irq_out
);

	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		logic [cbsc_pkg::DATA_W-1:0] sys_ctl;
		logic [cbsc_pkg::DC_W-1:0]   dev_ctl;
		logic [cbsc_pkg::SK_W-1:0]   pin_cfg;
		logic [cbsc_pkg::EVT_W-1:0]  status;
		logic [cbsc_pkg::EVT_W-1:0]  mask;
		logic [cbsc_pkg::SYNC_W-1:0] card_sync;
		logic [cbsc_pkg::SYNC_W-1:0] supply_sync;
		logic                        card_async_lvl;
		logic                        card_sync_lvl;
		logic                        card_prev;
		logic                        supply_lvl;
		logic                        supply_prev;
		logic [cbsc_pkg::DATA_W-1:0] rdata;
		logic                        clock_run_oe;
		logic                        func_irq;
		logic                        supply_req;
		logic                        id_we;
		logic                        irq;
	} cbsc_dev_s;

	cbsc_dev_s state_ff;
	cbsc_dev_s nxt_state;

	// ********************************************************************
	// Reset value of the whole state
	// ********************************************************************
	localparam cbsc_dev_s RESET_STATE = '{
		sys_ctl:        cbsc_pkg::SC_RESET,
		dev_ctl:        cbsc_pkg::DC_RESET,
		pin_cfg:        cbsc_pkg::SK_RESET,
		status:         cbsc_pkg::EVT_RESET,
		mask:           cbsc_pkg::EVT_RESET,
		card_sync:      '0,
		supply_sync:    '0,
		card_async_lvl: 1'b0,
		card_sync_lvl:  1'b0,
		card_prev:      1'b0,
		supply_lvl:     1'b0,
		supply_prev:    1'b0,
		rdata:          cbsc_pkg::DATA_ZERO,
		clock_run_oe:   1'b0,
		func_irq:       1'b0,
		supply_req:     1'b0,
		id_we:          1'b0,
		irq:            1'b0
	};

	// ********************************************************************
	// Next-state logic
	// ********************************************************************
	logic                        sel_lvl;
	logic                        card_detect;
	logic                        supply_detect;
	logic [cbsc_pkg::EVT_W-1:0]  events;
	logic [cbsc_pkg::EVT_W-1:0]  st_after;
	logic [cbsc_pkg::DATA_W-1:0] rd_word;
	logic                        hit_sc;
	logic                        hit_dc;
	logic                        hit_sk;
	logic                        hit_st;
	logic                        hit_mk;

	// Address decode
	always_comb begin
		hit_sc = (bus.addr == cbsc_pkg::OFS_SYSTEM_CONTROL);
		hit_dc = (bus.addr == cbsc_pkg::OFS_DEVICE_CONTROL);
		hit_sk = (bus.addr == cbsc_pkg::OFS_SOCKET_REQ_PIN);
		hit_st = (bus.addr == cbsc_pkg::OFS_EVENT_STATUS);
		hit_mk = (bus.addr == cbsc_pkg::OFS_EVENT_MASK);
	end

	// Read multiplexer, reserved bits zero, unmapped reads zero
	always_comb begin
		rd_word = cbsc_pkg::DATA_ZERO;
		if (hit_sc) begin
			rd_word = state_ff.sys_ctl & cbsc_pkg::SC_WMASK;
		end else if (hit_dc) begin
			rd_word[cbsc_pkg::DC_W-1:0] = state_ff.dev_ctl;
		end else if (hit_sk) begin
			rd_word[cbsc_pkg::SK_W-1:0] = state_ff.pin_cfg;
		end else if (hit_st) begin
			rd_word[cbsc_pkg::EVT_W-1:0] = state_ff.status;
		end else if (hit_mk) begin
			rd_word[cbsc_pkg::EVT_W-1:0] = state_ff.mask;
		end
	end

	always_comb begin
		nxt_state = state_ff;

		// Three-stage synchronisers, second and third must agree
		nxt_state.card_sync   = {state_ff.card_sync[1:0], card_request_in};
		nxt_state.supply_sync = {state_ff.supply_sync[1:0], bad_supply_in};
		if (state_ff.card_sync[1] == state_ff.card_sync[2]) begin
			nxt_state.card_async_lvl = state_ff.card_sync[2];
		end
		if (state_ff.supply_sync[1] == state_ff.supply_sync[2]) begin
			nxt_state.supply_lvl = state_ff.supply_sync[2];
		end

		// Single clocked sample for a source already on this clock
		nxt_state.card_sync_lvl = card_request_in;

		// Choose sampling path for card function requests
		sel_lvl = state_ff.sys_ctl[cbsc_pkg::SC_SAMPLING_MODE] ?
			state_ff.card_async_lvl : state_ff.card_sync_lvl;
		nxt_state.card_prev   = sel_lvl;
		card_detect           = sel_lvl & ~state_ff.card_prev;
		nxt_state.supply_prev = state_ff.supply_lvl;
		supply_detect = state_ff.supply_lvl & ~state_ff.supply_prev &
			~state_ff.sys_ctl[cbsc_pkg::SC_BAD_SUPPLY_DISABLE];

		// Register writes, only writable bits are stored
		if (bus.wr) begin
			if (hit_sc) begin
				nxt_state.sys_ctl = (bus.wdata & cbsc_pkg::SC_WMASK) |
					(state_ff.sys_ctl & ~cbsc_pkg::SC_WMASK);
			end else if (hit_dc) begin
				nxt_state.dev_ctl = (bus.wdata[cbsc_pkg::DC_W-1:0] & cbsc_pkg::DC_WMASK) |
					(state_ff.dev_ctl & ~cbsc_pkg::DC_WMASK);
				if (bus.wdata[cbsc_pkg::DC_FUNC_FLAG]) begin
					nxt_state.dev_ctl[cbsc_pkg::DC_FUNC_FLAG] = 1'b0;
				end
			end else if (hit_sk) begin
				nxt_state.pin_cfg = bus.wdata[cbsc_pkg::SK_W-1:0];
			end else if (hit_mk) begin
				nxt_state.mask = bus.wdata[cbsc_pkg::EVT_W-1:0];
			end
		end

		// Function flag: detection wins over a same-cycle clear
		if (card_detect) begin
			nxt_state.dev_ctl[cbsc_pkg::DC_FUNC_FLAG] = 1'b1;
		end

		// Sticky event status, cleared by a read, set wins
		events = '0;
		events[cbsc_pkg::EVT_CARD_FUNCTION] = card_detect;
		events[cbsc_pkg::EVT_BAD_SUPPLY]    = supply_detect;
		st_after = (bus.rd && hit_st) ? cbsc_pkg::EVT_RESET : state_ff.status;
		nxt_state.status = st_after | events;

		// Read data, valid only in the cycle after the strobe
		nxt_state.rdata = bus.rd ? rd_word : cbsc_pkg::DATA_ZERO;

		// Clock-run line: held driven low by override or local demand
		nxt_state.clock_run_oe =
			state_ff.sys_ctl[cbsc_pkg::SC_CLOCK_RUN_OVERRIDE] | clock_request_in;

		// Parallel interrupt output of the function flag
		nxt_state.func_irq =
			nxt_state.dev_ctl[cbsc_pkg::DC_FUNC_FLAG];

		// Bad-supply request forwarded only while valid
		nxt_state.supply_req = state_ff.supply_lvl &
			~state_ff.sys_ctl[cbsc_pkg::SC_BAD_SUPPLY_DISABLE];

		// Write gate for the external identifier registers
		nxt_state.id_we = nxt_state.sys_ctl[cbsc_pkg::SC_ID_WRITE_ENABLE];

		// Level interrupt from unmasked sticky bits
		nxt_state.irq = |(nxt_state.status & nxt_state.mask);
	end

	// ********************************************************************
	// State register
	// ********************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= RESET_STATE;
		end else if (ce_in) begin
			state_ff <= nxt_state;
		end
	end

	// ********************************************************************
	// Outputs
	// ********************************************************************
	assign bus.rdata                   = state_ff.rdata;
	assign clock_run_n_out             = 1'b0;  // Open drain, only pulls low
	assign clock_run_n_oe_out          = state_ff.clock_run_oe;
	assign card_function_irq_out       = state_ff.func_irq;
	assign bad_supply_request_out      = state_ff.supply_req;
	assign identifier_write_enable_out = state_ff.id_we;
	assign irq_out                     = state_ff.irq;

endmodule : cbsc_device

// file: design/cbsc_host.sv
`timescale 1ns/1ns
module cbsc_host (
	input  wire logic                         clk_in,
	input  wire logic                         rst_in,
	input  wire logic                         ce_in,
	cbsc_if.host                              bus,
	input  wire logic                         cmd_wr_in,
	input  wire logic                         cmd_rd_in,
	input  wire logic [cbsc_pkg::ADDR_W-1:0]  cmd_addr_in,
	input  wire logic [cbsc_pkg::DATA_W-1:0]  cmd_wdata_in,
	output logic [cbsc_pkg::DATA_W-1:0]       rsp_data_out,
	output logic                              rsp_valid_out
);

	// ********************************************************************
	// State
	// ********************************************************************
	typedef struct packed {
		logic [cbsc_pkg::ADDR_W-1:0] addr;
		logic [cbsc_pkg::DATA_W-1:0] wdata;
		logic                        wr;
		logic                        rd;
		logic                        rd_wait;
		logic [cbsc_pkg::DATA_W-1:0] rsp;
		logic                        valid;
	} cbsc_host_s;

	cbsc_host_s state_ff;
	cbsc_host_s nxt_state;
	logic [cbsc_pkg::DATA_W-1:0] safe;

	// Sanitise write data so protected fields stay at defaults
	always_comb begin
		safe = cbsc_pkg::DATA_ZERO;
		if (cmd_addr_in == cbsc_pkg::OFS_SYSTEM_CONTROL) begin
			safe = (cmd_wdata_in & cbsc_pkg::SC_WMASK & ~cbsc_pkg::SC_FORCE_MASK) |
				(cbsc_pkg::SC_RESET & cbsc_pkg::SC_FORCE_MASK);
		end else if (cmd_addr_in == cbsc_pkg::OFS_DEVICE_CONTROL) begin
			safe[cbsc_pkg::DC_W-1:0] =
				cmd_wdata_in[cbsc_pkg::DC_W-1:0] & cbsc_pkg::DC_HOST_PASS;
		end else if (cmd_addr_in == cbsc_pkg::OFS_SOCKET_REQ_PIN) begin
			safe[cbsc_pkg::SK_W-1:0] = cbsc_pkg::SK_RESET;
		end else begin
			safe[cbsc_pkg::EVT_W-1:0] = cmd_wdata_in[cbsc_pkg::EVT_W-1:0];
		end
	end

	// Strobe issue and read capture
	always_comb begin
		nxt_state       = state_ff;
		nxt_state.wr    = cmd_wr_in;
		nxt_state.rd    = cmd_rd_in & ~cmd_wr_in;
		nxt_state.addr  = cmd_addr_in;
		nxt_state.wdata = cmd_wr_in ? safe : cbsc_pkg::DATA_ZERO;
		// Read data stands only in the cycle after the bus strobe
		nxt_state.rd_wait = state_ff.rd;
		nxt_state.valid   = state_ff.rd_wait;
		if (state_ff.rd_wait) begin
			nxt_state.rsp = bus.rdata;
		end
	end

	// ********************************************************************
	// State register
	// ********************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_ff <= '0;
		end else if (ce_in) begin
			state_ff <= nxt_state;
		end
	end

	assign bus.addr      = state_ff.addr;
	assign bus.wdata     = state_ff.wdata;
	assign bus.wr        = state_ff.wr;
	assign bus.rd        = state_ff.rd;
	assign rsp_data_out  = state_ff.rsp;
	assign rsp_valid_out = state_ff.valid;

endmodule : cbsc_host

// file: verification/cbsc_sva.sv
`timescale 1ns/1ns
// ****************************************************************************
// Register bus checker
// ****************************************************************************
module cbsc_sva (
	input  wire logic                        clk_in,
	input  wire logic                        rst_in,
	input  wire logic [cbsc_pkg::ADDR_W-1:0] addr,
	input  wire logic [cbsc_pkg::DATA_W-1:0] wdata,
	input  wire logic                        wr,
	input  wire logic                        rd,
	input  wire logic [cbsc_pkg::DATA_W-1:0] rdata
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	// Read of system control
	sequence sc_read;
		rd && addr == 8'h80;
	endsequence

	chk_sc_reserved_zero : assert property (
		sc_read |=> (rdata & 32'hFFD0FFF1) == 32'h00000000)
		else $error("system control reserved bits not zero");
	chk_sc_dma_defaults : assert property (
		sc_read |=> rdata[19:16] == 4'h4)
		else $error("system control DMA fields off default");
	chk_dc_read_clean : assert property (
		rd && addr == 8'h91 |=> rdata[31:1] == 31'h00000000)
		else $error("device control read shows forbidden bits");
	chk_sk_read_zero : assert property (
		rd && addr == 8'h94 |=> rdata == 32'h00000000)
		else $error("socket pin register not zero");
	chk_sc_write_safe : assert property (
		wr && addr == 8'h80 |-> (wdata & 32'hFFD0FFF1) == 32'h00000000
			&& wdata[19:16] == 4'h4)
		else $error("unsafe system control write");
	chk_dc_write_safe : assert property (
		wr && addr == 8'h91 |-> wdata[31:1] == 31'h00000000)
		else $error("unsafe device control write");
	chk_sk_write_safe : assert property (
		wr && addr == 8'h94 |-> wdata == 32'h00000000)
		else $error("unsafe socket pin write");
	chk_unmapped_read : assert property (
		rd && !(addr inside {8'h80, 8'h91, 8'h94, 8'hA0, 8'hA4}) |=> rdata == 32'h00000000)
		else $error("unmapped read not zero");

	// Main scenarios reached
	cov_sc_write : cover property (wr && addr == 8'h80);
	cov_flag_seen : cover property (rd && addr == 8'h91 ##1 rdata[0]);
	cov_status_seen : cover property (rd && addr == 8'hA0 ##1 rdata[1]);
endmodule : cbsc_sva

// file: verification/card_bridge_system_control_bench.sv
`timescale 1ns/1ns
module card_bridge_system_control_bench;
	logic        clk_in;
	logic        rst_in;
	logic        cmd_wr, cmd_rd, card_req, bad_supply, clk_req;
	logic [7:0]  cmd_addr;
	logic [31:0] cmd_wdata, rsp_data, d, v;
	logic        rsp_valid, run_n, run_n_oe, func_irq, bad_req, id_we, irq;
	logic        ce;
	int          err_count, num_checks, cycles;
	integer      seed;

	// ************************************************************************
	// Both ends and checker
	// ************************************************************************
	cbsc_if cbsc_if_inst ();
	cbsc_device cbsc_device_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.bus(cbsc_if_inst.device), .card_request_in(card_req), .bad_supply_in(bad_supply),
		.clock_request_in(clk_req), .clock_run_n_out(run_n), .clock_run_n_oe_out(run_n_oe),
		.card_function_irq_out(func_irq), .bad_supply_request_out(bad_req),
		.identifier_write_enable_out(id_we), .irq_out(irq));
	cbsc_host cbsc_host_inst (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
		.bus(cbsc_if_inst.host), .cmd_wr_in(cmd_wr), .cmd_rd_in(cmd_rd),
		.cmd_addr_in(cmd_addr), .cmd_wdata_in(cmd_wdata), .rsp_data_out(rsp_data),
		.rsp_valid_out(rsp_valid));
	cbsc_sva cbsc_sva_inst (.clk_in(clk_in), .rst_in(rst_in), .addr(cbsc_if_inst.addr),
		.wdata(cbsc_if_inst.wdata), .wr(cbsc_if_inst.wr), .rd(cbsc_if_inst.rd),
		.rdata(cbsc_if_inst.rdata));

	// Clock, 50 ns period
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end

	// Hang guard
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			close_out();
		end
	end

	// ************************************************************************
	// Tasks
	// ************************************************************************
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	// Command write, ends once device outputs have settled
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] wv);
		@(posedge clk_in);
		cmd_wr    <= 1'b1;
		cmd_addr  <= a;
		cmd_wdata <= wv;
		@(posedge clk_in);
		cmd_wr <= 1'b0;
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
	endtask : wr_reg

	// Command read, bounded wait for the response pulse
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
		int n;
		@(posedge clk_in);
		cmd_rd   <= 1'b1;
		cmd_addr <= a;
		@(posedge clk_in);
		cmd_rd <= 1'b0;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
		end while (rsp_valid !== 1'b1 && n < 8);
		check({name, "_valid"}, 32'h00000001, {31'h0, rsp_valid});
		check(name, exp, rsp_data);
	endtask : rd_chk

	// Host keeps only the writable bits, DMA fields at default
	function automatic logic [31:0] sc_exp(input logic [31:0] x);
		return (x & 32'h0020000E) | 32'h00040000;
	endfunction : sc_exp

	// ************************************************************************
	// Main sequence
	// ************************************************************************
	initial begin
		seed = 32'hE7AA2D71;
		rst_in = 1'b1;
		{cmd_wr, cmd_rd, card_req, bad_supply, clk_req} = 5'h00;
		ce = 1'b1;
		cmd_addr = 8'h00;
		cmd_wdata = 32'h00000000;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		@(negedge clk_in);
		rd_chk(8'h80, 32'h00040004, "sc_reset");
		check("id_we_reset", 32'h0, {31'h0, id_we});
		rd_chk(8'h91, 32'h00000000, "dc_reset");
		rd_chk(8'h94, 32'h00000000, "sk_reset");
		// Random and all-ones writes to system control, device control and socket pin, plus an unmapped one
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
			wr_reg(8'h80, d);
			check("id_we", {31'h0, d[3]}, {31'h0, id_we});
			check("run_oe", {31'h0, d[1]}, {31'h0, run_n_oe});
			check("run_n", 32'h0, {31'h0, run_n});
			rd_chk(8'h80, sc_exp(d), "sc_rw");
			wr_reg(8'h91, d);
			rd_chk(8'h91, 32'h00000000, "dc_rw");
			wr_reg(8'h94, d);
			rd_chk(8'h94, 32'h00000000, "sk_rw");
			wr_reg(8'h84, d);
			rd_chk(8'h84, 32'h00000000, "unmapped");
		end
		// Local clock demand without override
		wr_reg(8'h80, 32'h00040000);
		clk_req <= 1'b1;
		wr_reg(8'h84, 32'h00000000);
		check("run_oe_req", 32'h1, {31'h0, run_n_oe});
		clk_req <= 1'b0;
		// Card request in both sampling modes, masked and unmasked
		for (int m = 0; m < 2; m++) begin
			wr_reg(8'h80, m ? 32'h00040004 : 32'h00040000);
			wr_reg(8'hA4, m);
			rd_chk(8'hA4, m, "mask");
			card_req <= 1'b1;
			repeat (8) @(posedge clk_in);
			@(negedge clk_in);
			check("func_irq", 32'h1, {31'h0, func_irq});
			check("irq", m, {31'h0, irq});
			card_req <= 1'b0;
			rd_chk(8'h91, 32'h00000001, "flag_set");
			rd_chk(8'hA0, 32'h00000001, "status");
			rd_chk(8'hA0, 32'h00000000, "status_clr");
			wr_reg(8'h91, 32'h00000001);
			check("flag_clr", 32'h0, {31'h0, func_irq});
			check("irq_clr", 32'h0, {31'h0, irq});
		end
		// Bad supply request, then disabled
		wr_reg(8'hA4, 32'h00000003);
		bad_supply <= 1'b1;
		repeat (8) @(posedge clk_in);
		@(negedge clk_in);
		check("bad_req", 32'h1, {31'h0, bad_req});
		check("irq_bad", 32'h1, {31'h0, irq});
		rd_chk(8'hA0, 32'h00000002, "bad_status");
		wr_reg(8'h80, 32'h00240004);
		check("bad_req_off", 32'h0, {31'h0, bad_req});
		bad_supply <= 1'b0;
		// Clock enable low: a command pulse is lost, registers hold
		ce <= 1'b0;
		wr_reg(8'h80, 32'h0004000C);
		check("ce_hold", 32'h0, {31'h0, id_we});
		ce <= 1'b1;
		rd_chk(8'h80, 32'h00240004, "ce_sc");
		close_out();
	end
endmodule : card_bridge_system_control_bench
